/* shared/ecpm_pkg.sv */
package ecpm_pkg;
    // Register window offsets, relative to the port base
    localparam logic [10:0] ECPM_OFS_FIFO   = 11'h400;
    localparam logic [10:0] ECPM_OFS_CFGB   = 11'h401;
    localparam logic [10:0] ECPM_OFS_ECR    = 11'h402;
    // Extended control register fields
    localparam int ECPM_MODE_HI   = 7;
    localparam int ECPM_MODE_LO   = 5;
    localparam int ECPM_FLT_BIT   = 4;
    localparam int ECPM_DMA_BIT   = 3;
    localparam int ECPM_SVC_BIT   = 2;
    localparam int ECPM_FULL_BIT  = 1;
    localparam int ECPM_EMPTY_BIT = 0;
    // Reset value: standard mode, fault irq off, dma off, service masked
    localparam logic [7:0] ECPM_ECR_RST = 8'h15;
    // Configuration register A constant (one-byte word)
    localparam logic [7:0] ECPM_CFGA_VAL = 8'h10;
    // FIFO geometry
    localparam int ECPM_DEPTH  = 16;
    localparam int ECPM_AW     = 4;
    localparam int ECPM_CW     = 5;
    localparam logic [4:0] ECPM_DEPTH_C = 5'h10;
    // Mode codes
    typedef enum logic [2:0] {
        ECPM_M_STD  = 3'h0,
        ECPM_M_BIDI = 3'h1,
        ECPM_M_FIFO = 3'h2,
        ECPM_M_ECP  = 3'h3,
        ECPM_M_EPP  = 3'h4,
        ECPM_M_RSV  = 3'h5,
        ECPM_M_TEST = 3'h6,
        ECPM_M_CFG  = 3'h7
    } ecpm_mode_type;
endpackage : ecpm_pkg

/* verilog/ecpm_mem.sv */
`timescale 1ns/1ps
`default_nettype none
// Byte store for the FIFO; read data comes out of a register
module ecpm_mem (
    // Clock
    input  wire logic       ref_clk,
    // Write side
    input  wire logic       wr_en,
    input  wire logic [3:0] wr_addr,
    input  wire logic [7:0] wr_data,
    // Read side
    input  wire logic [3:0] rd_addr,
    output logic      [7:0] rd_data
);
    import ecpm_pkg::*;
    logic [7:0] mem_r [ECPM_DEPTH];   // Storage array

    // Write port and registered read
    always_ff @(posedge ref_clk) begin
        if (wr_en) begin
            mem_r[wr_addr] <= wr_data;
        end
        rd_data <= mem_r[rd_addr];
    end
endmodule : ecpm_mem
`default_nettype wire

/* verilog/ecpm_fault_edge.sv */
`timescale 1ns/1ps
`default_nettype none
// Fault interrupt: falling edge of fault, or disable cleared while asserted
module ecpm_fault_edge (
    // Clock and reset
    input  wire logic ref_clk,
    input  wire logic rst_n,
    // Controls
    input  wire logic ecp_mode,
    input  wire logic fault_irq_disable_n,
    input  wire logic peripheral_fault_n,
    // Interrupt pulse
    output logic      fault_irq
);
    import ecpm_pkg::*;
    typedef struct packed {
        logic flt_d;    // Previous fault level
        logic dis_d;    // Previous disable bit
        logic irq;      // Registered pulse
    } ecpm_fe_type;
    ecpm_fe_type st_r, st_nxt;

    // Next-state logic
    always_comb begin
        st_nxt       = st_r;
        st_nxt.flt_d = peripheral_fault_n;
        st_nxt.dis_d = fault_irq_disable_n;
        st_nxt.irq   = 1'b0;
        if (ecp_mode && !fault_irq_disable_n) begin
            // Falling edge of fault
            if (st_r.flt_d && !peripheral_fault_n) begin
                st_nxt.irq = 1'b1;
            end
            // Enable opened while fault already low
            if (st_r.dis_d && !peripheral_fault_n) begin
                st_nxt.irq = 1'b1;
            end
        end
    end

    // State register
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= '{flt_d: 1'b1, dis_d: 1'b1, irq: 1'b0};
        end else begin
            st_r <= st_nxt;
        end
    end

    assign fault_irq = st_r.irq;
endmodule : ecpm_fault_edge
`default_nettype wire

/* verilog/ecpm_ctrl.sv */
// Overview of operation
// - Three-bit mode field selects operating mode
// - Fault falling edge interrupts unless disabled, ECP
// - Enabling with fault asserted raises interrupt
// - DMA enable allows DMA once service cleared
// - Service bit set masks DMA and service interrupts
// - Hardware sets service bit; software write one silent
// - DMA terminal count sets service bit
// - Free or queued bytes at or over threshold set service
// - Full flag when no free position
// - Empty flag when no byte queued
// - Standard mode resets FIFO, open-drain controls
// - Bidirectional mode direction tristates data lines
// - FIFO mode sends bytes by standard handshake
// - ECP mode shares FIFO; reverse fills it
// - Code 100 EPP only if enabled; 101 reserved
// - Test mode FIFO read/write, never transmitted
// - Configuration mode maps config registers at FIFO
// - Config B 5:3 reads encoded IRQ
// - Config B 2:0 reads DMA channel
// - Entering ECP or FIFO mode starts transfer
// - Leaving reverse ECP drops auto linefeed, discards
// - Clearing service with condition true interrupts now
// - Service threshold is setting plus one
`timescale 1ns/1ps
`default_nettype none
module ecpm_ctrl (
    // Clock and reset
    input  wire logic       ref_clk,
    input  wire logic       rst_n,
    // Register port (documented offsets, one access a cycle)
    input  wire logic [10:0] reg_addr,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    input  wire logic [7:0]  reg_wdata,
    output logic      [7:0]  reg_rdata,
    // Control register inputs from the rest of the port
    input  wire logic        direction,
    input  wire logic [7:0]  data_reg,
    input  wire logic [7:0]  data_lines_in,
    // Configuration inputs
    input  wire logic [3:0]  fifo_level_setting,
    input  wire logic [3:0]  irq_select,
    input  wire logic [2:0]  dma_select,
    input  wire logic        epp_option_config,
    // DMA
    input  wire logic        dma_tc,
    output logic             dma_req,
    // Link-side FIFO access (handshake engine)
    input  wire logic        link_push,
    input  wire logic [7:0]  link_wdata,
    input  wire logic        link_pop,
    output logic      [7:0]  link_rdata,
    input  wire logic        reverse_busy,
    // Peripheral fault
    input  wire logic        peripheral_fault_n,
    // Mode outputs
    output logic             xfer_fwd_std,
    output logic             xfer_fwd_ecp,
    output logic             xfer_rev_ecp,
    output logic             epp_active,
    output logic             ctrl_open_drain,
    output logic             data_oe,
    output logic             data_read_live,
    output logic             auto_linefeed_force_off,
    // Interrupt pulses
    output logic             service_irq,
    output logic             fault_irq
);
    import ecpm_pkg::*;

    // All state of this module
    typedef struct packed {
        logic [2:0] mode;     // Mode field
        logic       flt_dis;  // Fault irq disable
        logic       dma_en;   // DMA allow
        logic       svc;      // Service request mask
        logic [3:0] wp;       // Write pointer
        logic [3:0] rp;       // Read pointer
        logic [4:0] cnt;      // Occupancy
        logic [7:0] rdata;    // Read data hold
        logic       irq;      // Service pulse
        logic       rd_mem;   // Read took from the store
        logic       rev_d;    // Previous reverse ECP flag
    } ecpm_st_type;
    ecpm_st_type st_r, st_nxt;

    // Encode IRQ number into readback code
    function automatic logic [2:0] irq_code(input logic [3:0] n);
        case (n)
            4'hf:    irq_code = 3'h6;
            4'he:    irq_code = 3'h5;
            4'hb:    irq_code = 3'h4;
            4'ha:    irq_code = 3'h3;
            4'h9:    irq_code = 3'h2;
            4'h7:    irq_code = 3'h1;
            4'h5:    irq_code = 3'h7;
            default: irq_code = 3'h0;
        endcase
    endfunction : irq_code

    // Decode mode field into the FIFO-using modes
    function automatic logic uses_fifo(input logic [2:0] m);
        uses_fifo = (m == ECPM_M_FIFO) || (m == ECPM_M_ECP) || (m == ECPM_M_TEST);
    endfunction : uses_fifo

    logic [7:0] mem_q;        // Store read data
    logic       mem_we;       // Store write strobe
    logic       push;         // Accepted push
    logic       pop;          // Accepted pop
    logic       host_fifo_wr; // Host write at FIFO offset
    logic       host_fifo_rd; // Host read at FIFO offset
    logic       full;         // Full flag
    logic       empty;        // Empty flag
    logic [4:0] thr;          // Service threshold
    logic       cond;         // Armed service condition
    logic [7:0] ecr_rd;       // Extended control readback
    logic       mode_ecp;     // Current mode is ECP

    // Store instance
    ecpm_mem u_mem (
        .ref_clk (ref_clk),
        .wr_en   (mem_we),
        .wr_addr (st_r.wp),
        .wr_data (host_fifo_wr ? reg_wdata : link_wdata),
        .rd_addr (st_r.rp),
        .rd_data (mem_q)
    );

    assign mode_ecp = (st_r.mode == ECPM_M_ECP);

    // Fault edge detector
    ecpm_fault_edge u_fault (
        .ref_clk             (ref_clk),
        .rst_n               (rst_n),
        .ecp_mode            (mode_ecp),
        .fault_irq_disable_n (st_r.flt_dis),
        .peripheral_fault_n  (peripheral_fault_n),
        .fault_irq           (fault_irq)
    );

    // FIFO flags and threshold
    always_comb begin
        full  = (st_r.cnt == ECPM_DEPTH_C);
        empty = (st_r.cnt == 5'h00);
        thr   = {1'b0, fifo_level_setting} + 5'h01;
        host_fifo_wr = reg_wr && (reg_addr == ECPM_OFS_FIFO) && uses_fifo(st_r.mode);
        host_fifo_rd = reg_rd && (reg_addr == ECPM_OFS_FIFO) && uses_fifo(st_r.mode);
        push = 1'b0;
        pop  = 1'b0;
        // Test mode: host pushes and pops only, nothing goes out
        if (st_r.mode == ECPM_M_TEST) begin
            push = host_fifo_wr && !full;
            pop  = host_fifo_rd && !empty;
        end else if (st_r.mode == ECPM_M_FIFO) begin
            push = host_fifo_wr && !full;
            pop  = link_pop && !empty;
        end else if (mode_ecp && !direction) begin
            push = host_fifo_wr && !full;
            pop  = link_pop && !empty;
        end else if (mode_ecp && direction) begin
            push = link_push && !full;
            pop  = host_fifo_rd && !empty;
        end
        mem_we = push;
        // Armed condition, exactly one case at a time
        if (st_r.dma_en) begin
            cond = dma_tc;
        end else if (!direction) begin
            cond = (ECPM_DEPTH_C - st_r.cnt) >= thr;
        end else begin
            cond = st_r.cnt >= thr;
        end
    end

    // Next-state logic
    always_comb begin
        st_nxt     = st_r;
        st_nxt.irq = 1'b0;
        st_nxt.rd_mem = pop && host_fifo_rd;
        st_nxt.rev_d  = mode_ecp && direction;
        // Pointers and count move together with the flags
        if (push) begin
            st_nxt.wp = st_r.wp + 4'h1;
        end
        if (pop) begin
            st_nxt.rp = st_r.rp + 4'h1;
        end
        st_nxt.cnt = st_r.cnt + {4'h0, push} - {4'h0, pop};
        // Register writes to the extended control register
        if (reg_wr && reg_addr == ECPM_OFS_ECR) begin
            st_nxt.mode    = reg_wdata[ECPM_MODE_HI:ECPM_MODE_LO];
            st_nxt.flt_dis = reg_wdata[ECPM_FLT_BIT];
            st_nxt.dma_en  = reg_wdata[ECPM_DMA_BIT];
            st_nxt.svc     = reg_wdata[ECPM_SVC_BIT];
        end
        // Service request: armed only while mask is clear
        if (!st_r.svc && cond) begin
            st_nxt.irq = 1'b1;
            st_nxt.svc = 1'b1;
        end
        // Clearing the mask while the condition holds fires at once
        if (st_r.svc && reg_wr && reg_addr == ECPM_OFS_ECR
            && !reg_wdata[ECPM_SVC_BIT] && cond) begin
            st_nxt.irq = 1'b1;
            st_nxt.svc = 1'b1;
        end
        // Standard mode holds the FIFO in reset; leaving reverse ECP drops extras
        if (st_nxt.mode == ECPM_M_STD || (st_r.rev_d && !(mode_ecp && direction))) begin
            st_nxt.wp  = 4'h0;
            st_nxt.rp  = 4'h0;
            st_nxt.cnt = 5'h00;
        end
        // Read data hold for the last popped byte (re-read on underrun)
        if (st_r.rd_mem) begin
            st_nxt.rdata = mem_q;
        end
    end

    // State register
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= '{mode: ECPM_ECR_RST[ECPM_MODE_HI:ECPM_MODE_LO],
                      flt_dis: ECPM_ECR_RST[ECPM_FLT_BIT],
                      dma_en: ECPM_ECR_RST[ECPM_DMA_BIT],
                      svc: ECPM_ECR_RST[ECPM_SVC_BIT],
                      wp: 4'h0, rp: 4'h0, cnt: 5'h00, rdata: 8'h00,
                      irq: 1'b0, rd_mem: 1'b0, rev_d: 1'b0};
        end else begin
            st_r <= st_nxt;
        end
    end

    // Register readback
    always_comb begin
        ecr_rd = {st_r.mode, st_r.flt_dis, st_r.dma_en, st_r.svc, full, empty};
        reg_rdata = 8'h00;
        case (reg_addr)
            ECPM_OFS_FIFO: begin
                if (st_r.mode == ECPM_M_CFG) begin
                    reg_rdata = ECPM_CFGA_VAL;
                end else if (st_r.rd_mem) begin
                    reg_rdata = mem_q;
                end else begin
                    reg_rdata = st_r.rdata;
                end
            end
            ECPM_OFS_CFGB: begin
                if (st_r.mode == ECPM_M_CFG) begin
                    reg_rdata = {2'b00, irq_code(irq_select),
                                 (dma_select <= 3'h3) ? dma_select : 3'h0};
                end
            end
            ECPM_OFS_ECR: begin
                reg_rdata = ecr_rd;
            end
            default: begin
                reg_rdata = 8'h00;
            end
        endcase
    end

    // Mode-derived outputs
    always_comb begin
        xfer_fwd_std = (st_r.mode == ECPM_M_FIFO);
        xfer_fwd_ecp = mode_ecp && !direction;
        xfer_rev_ecp = mode_ecp && direction && !full;
        epp_active   = (st_r.mode == ECPM_M_EPP) && epp_option_config;
        ctrl_open_drain = (st_r.mode == ECPM_M_STD);
        // Every mode but standard and FIFO lets direction float the lines
        data_oe = !(direction && st_r.mode != ECPM_M_STD
                    && st_r.mode != ECPM_M_FIFO);
        data_read_live = (st_r.mode != ECPM_M_STD);
        auto_linefeed_force_off = st_r.rev_d && !(mode_ecp && direction) && reverse_busy;
        dma_req = st_r.dma_en && !st_r.svc && !full && !direction
                  && uses_fifo(st_r.mode);
        service_irq = st_r.irq;
        link_rdata  = mem_q;
    end

    // Data register value is read by the outer data-port logic
    logic unused_ok;
    assign unused_ok = ^{data_reg, data_lines_in};
endmodule : ecpm_ctrl
`default_nettype wire

/* test/ecpm_ctrl_sva.sv */
`timescale 1ns/1ps
`default_nettype none
// Port-level checks of mode, service and fault behaviour
module ecpm_ctrl_sva
    import ecpm_pkg::*;
(
    // Clock and reset
    input wire logic        ref_clk,
    input wire logic        rst_n,
    // Register port
    input wire logic [10:0] reg_addr,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [7:0]  reg_wdata,
    input wire logic [7:0]  reg_rdata,
    // Levels from outside
    input wire logic        direction,
    input wire logic [2:0]  dma_select,
    input wire logic        epp_option_config,
    input wire logic        peripheral_fault_n,
    // Outputs watched
    input wire logic        dma_req,
    input wire logic        ctrl_open_drain,
    input wire logic        data_oe,
    input wire logic        epp_active,
    input wire logic        service_irq,
    input wire logic        fault_irq
);
    logic [2:0] mode_s; // Shadow of the mode field
    logic       fdis_s; // Shadow of the fault disable bit
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    // Track what software last wrote to the control register
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            mode_s <= 3'h0;
            fdis_s <= 1'b1;
        end else if (reg_wr && reg_addr == ECPM_OFS_ECR) begin
            mode_s <= reg_wdata[7:5];
            fdis_s <= reg_wdata[4];
        end
    end
    // Control register write
    sequence ecr_wr_s;
        reg_wr && reg_addr == ECPM_OFS_ECR;
    endsequence
    // Fault edge while the interrupt is armed
    sequence fault_fall_s;
        mode_s == 3'h3 && !fdis_s && $fell(peripheral_fault_n);
    endsequence
    mode_read_a: assert property (reg_rd && reg_addr == ECPM_OFS_ECR |->
        reg_rdata[7:5] == mode_s) else $error("mode field read back wrong");
    svc_pulse_a: assert property (service_irq |=> !service_irq)
        else $error("service pulse longer than one cycle");
    svc_silent_a: assert property (ecr_wr_s ##0 reg_wdata[2] |=> ##1 !service_irq)
        else $error("service write of one raised an interrupt");
    dma_off_a: assert property (ecr_wr_s ##0 (!reg_wdata[3] || reg_wdata[2]) |=> !dma_req)
        else $error("dma request while blocked");
    fault_edge_a: assert property (fault_fall_s |-> ##[1:2] fault_irq)
        else $error("fault edge gave no interrupt");
    fault_mode_a: assert property (fault_irq |-> $past(mode_s) == 3'h3)
        else $error("fault interrupt outside ecp mode");
    fault_arm_a: assert property (ecr_wr_s ##0 (mode_s == 3'h3 && fdis_s && !reg_wdata[4]
        && reg_wdata[7:5] == 3'h3 && !peripheral_fault_n) |-> ##[1:2] fault_irq)
        else $error("enable with fault held gave no interrupt");
    open_drain_a: assert property (ctrl_open_drain == (mode_s == 3'h0))
        else $error("open drain level wrong for mode");
    epp_sel_a: assert property (epp_active == (mode_s == 3'h4 && epp_option_config))
        else $error("epp select wrong");
    dma_code_a: assert property (reg_rd && reg_addr == ECPM_OFS_CFGB && mode_s == 3'h7 |->
        reg_rdata[2:0] == ((dma_select > 3'h3) ? 3'h0 : dma_select))
        else $error("dma channel code wrong");
    data_tri_a: assert property (mode_s == 3'h1 && direction |-> !data_oe)
        else $error("data lines driven in reverse");
    data_drive_a: assert property (mode_s == 3'h0 |-> data_oe)
        else $error("data lines released in standard mode");
endmodule : ecpm_ctrl_sva
bind ecpm_ctrl ecpm_ctrl_sva i_ecpm_ctrl_sva (.ref_clk, .rst_n, .reg_addr, .reg_wr, .reg_rd,
    .reg_wdata, .reg_rdata, .direction, .dma_select, .epp_option_config, .peripheral_fault_n,
    .dma_req, .ctrl_open_drain, .data_oe, .epp_active, .service_irq, .fault_irq);
`default_nettype wire

/* test/ecpm_printer_model.sv */
`timescale 1ns/1ps
`default_nettype none
// Slow peripheral: moves a set number of bytes, drives the fault line
module ecpm_printer_model (
    // Clock and reset
    input  wire logic       ref_clk,
    input  wire logic       rst_n,
    // Port state and bench controls
    input  wire logic       fwd_on,
    input  wire logic       rev_on,
    input  wire logic [3:0] want,
    input  wire logic       fault_req,
    // Link side
    output logic            link_push,
    output logic            link_pop,
    output logic [7:0]      link_wdata,
    output logic            got_vld,
    output logic            peripheral_fault_n
);
    logic [1:0] tick_r; // Paces one byte every fourth cycle
    logic [3:0] cnt_r;  // Bytes moved in this transfer phase
    // Pop or push only up to the bench's count; idle data keeps toggling
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            tick_r <= 2'h0;
            cnt_r <= 4'h0;
            link_pop <= 1'b0;
            link_push <= 1'b0;
            link_wdata <= 8'h00;
            got_vld <= 1'b0;
            peripheral_fault_n <= 1'b1;
        end else begin
            tick_r <= tick_r + 2'h1;
            link_pop <= fwd_on && cnt_r < want && tick_r == 2'h0;
            link_push <= rev_on && cnt_r < want && tick_r == 2'h0;
            link_wdata <= (rev_on && tick_r == 2'h0) ? 8'h5a + {4'h0, cnt_r} : ~link_wdata;
            got_vld <= link_pop;
            peripheral_fault_n <= !fault_req;
            if (!fwd_on && !rev_on) begin
                cnt_r <= 4'h0;
            end else if (cnt_r < want && tick_r == 2'h0) begin
                cnt_r <= cnt_r + 4'h1;
            end
        end
    end
endmodule : ecpm_printer_model
`default_nettype wire

/* test/test_ecp_port_mode_control.sv */
`timescale 1ns/1ps
`default_nettype none
module test_ecp_port_mode_control;
    import ecpm_pkg::*;
    logic        ref_clk, rst_n, reg_wr, reg_rd, direction, epp_option_config, dma_tc;
    logic [10:0] reg_addr;
    logic [7:0]  reg_wdata, reg_rdata, link_wdata, link_rdata;
    logic [3:0]  fifo_level_setting, irq_select, want, lvl;
    logic [2:0]  dma_select;
    logic        link_push, link_pop, got_vld, peripheral_fault_n, fault_req, frd_d;
    logic        dma_req, xfer_fwd_std, xfer_fwd_ecp, xfer_rev_ecp, epp_active;
    logic        ctrl_open_drain, data_oe, data_read_live, service_irq, fault_irq;
    logic        auto_linefeed_force_off, rbusy;
    logic [15:0] q[$];  // Expected register reads: mask, value
    logic [7:0]  ql[$]; // Bytes the peripheral should receive
    logic [7:0]  d[16];
    logic [15:0] e;
    logic [31:0] seed, r;
    logic [2:0]  irqt[16] = '{3'h0, 3'h0, 3'h0, 3'h0, 3'h0, 3'h7, 3'h0, 3'h1,
                              3'h0, 3'h2, 3'h3, 3'h4, 3'h0, 3'h0, 3'h5, 3'h6};
    int          mismatches, checked, sirq, firq, alfn, i;
    ecpm_ctrl i_ecpm_ctrl (.ref_clk, .rst_n, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata,
        .direction, .data_reg(8'h00), .data_lines_in(8'h00), .fifo_level_setting, .irq_select,
        .dma_select, .epp_option_config, .dma_tc, .dma_req, .link_push, .link_wdata, .link_pop,
        .link_rdata, .reverse_busy(rbusy), .peripheral_fault_n, .xfer_fwd_std, .xfer_fwd_ecp,
        .xfer_rev_ecp, .epp_active, .ctrl_open_drain, .data_oe, .data_read_live,
        .auto_linefeed_force_off, .service_irq, .fault_irq);
    ecpm_printer_model i_ecpm_printer_model (.ref_clk, .rst_n, .fwd_on(xfer_fwd_std | xfer_fwd_ecp),
        .rev_on(xfer_rev_ecp), .want, .fault_req, .link_push, .link_pop, .link_wdata, .got_vld,
        .peripheral_fault_n);
    // Clock at 125 MHz
    initial begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch at %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic cyc(input int n);
        repeat (n) @(negedge ref_clk);
    endtask : cyc
    task automatic wr(input logic [10:0] a, input logic [7:0] v);
        @(negedge ref_clk);
        reg_addr = a;
        reg_wdata = v;
        reg_wr = 1'b1;
        @(negedge ref_clk);
        reg_wr = 1'b0;
    endtask : wr
    // Read; a FIFO read keeps the address one more cycle for its late data
    task automatic rd(input logic [10:0] a, input logic [7:0] v, input logic [7:0] m);
        @(negedge ref_clk);
        reg_addr = a;
        reg_rd = 1'b1;
        q.push_back({m, v});
        @(negedge ref_clk);
        reg_rd = 1'b0;
        if (a == ECPM_OFS_FIFO) @(negedge ref_clk);
    endtask : rd
    task automatic wc(input logic [7:0] v);
        wr(ECPM_OFS_ECR, v);
    endtask : wc
    task automatic re(input logic [7:0] v);
        rd(ECPM_OFS_ECR, v, 8'hff);
    endtask : re
    task automatic print_verdict;
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : print_verdict
    // Output watcher: compares reads and received bytes, counts pulses
    always @(posedge ref_clk) begin
        if (frd_d || (reg_rd && reg_addr != ECPM_OFS_FIFO)) begin
            e = q.pop_front();
            chk(reg_rdata & e[15:8], e[7:0]);
        end
        if (got_vld === 1'b1) chk(link_rdata, ql.pop_front());
        if (service_irq === 1'b1) sirq++;
        if (fault_irq === 1'b1) firq++;
        if (auto_linefeed_force_off === 1'b1) alfn++;
        frd_d <= reg_rd && reg_addr == ECPM_OFS_FIFO;
    end
    // Watchdog: the tests need a few hundred cycles, well under the 12500-cycle limit
    initial begin
        #100000;
        mismatches++;
        print_verdict();
    end
    // Main sequence; every mode change keeps the legal paths
    initial begin
        {rst_n, reg_wr, reg_rd, direction, epp_option_config, dma_tc, fault_req, rbusy} = 8'h00;
        {reg_addr, reg_wdata, fifo_level_setting, irq_select, dma_select, want} = 34'h0;
        seed = 32'h1fe6;
        repeat (4) @(posedge ref_clk);
        @(negedge ref_clk);
        rst_n = 1'b1;
        re(8'h15);
        $display("test reset done");
        wc(8'hf4);
        for (i = 0; i < 16; i++) begin
            irq_select = i[3:0];
            dma_select = i[2:0];
            rd(ECPM_OFS_CFGB, {2'h0, irqt[i], (i[2:0] > 3'h3) ? 3'h0 : i[2:0]}, 8'hbf);
        end
        rd(ECPM_OFS_FIFO, ECPM_CFGA_VAL, 8'hff);
        wc(8'h14);
        $display("test config done");
        wc(8'hd4);
        chk({7'h0, ctrl_open_drain}, 8'h00);
        for (i = 0; i < 17; i++) begin
            r = $random(seed);
            if (i < 16) d[i] = r[7:0];
            wr(ECPM_OFS_FIFO, r[7:0]);
            if (i == 0) re(8'hd4);
        end
        re(8'hd6);
        r = $random(seed);
        lvl = r[3:0];
        fifo_level_setting = lvl;
        wc(8'hd0);
        for (i = 0; i < 16; i++) begin
            if (i == lvl) chk(sirq[7:0], 8'h00);
            rd(ECPM_OFS_FIFO, d[i], 8'hff);
        end
        cyc(2);
        chk(sirq[7:0], 8'h01);
        rd(ECPM_OFS_FIFO, d[15], 8'hff);
        re(8'hd5);
        wc(8'hd0);
        wc(8'hd4);
        cyc(2);
        chk(sirq[7:0], 8'h02);
        wr(ECPM_OFS_FIFO, 8'h44);
        wc(8'h14);
        wc(8'hd4);
        re(8'hd5);
        wc(8'h14);
        $display("test fifo done");
        wc(8'h34);
        direction = 1'b1;
        cyc(1);
        chk({6'h0, data_oe, data_read_live}, 8'h01);
        wc(8'h14);
        chk({6'h0, data_oe, ctrl_open_drain}, 8'h03);
        wc(8'h34);
        direction = 1'b0;
        epp_option_config = 1'b1;
        wc(8'h94);
        chk({7'h0, epp_active}, 8'h01);
        wc(8'h34);
        epp_option_config = 1'b0;
        wc(8'h94);
        chk({7'h0, epp_active}, 8'h00);
        wc(8'h14);
        $display("test modes done");
        wc(8'h5c);
        chk({7'h0, dma_req}, 8'h00);
        wc(8'h58);
        chk({6'h0, xfer_fwd_std, dma_req}, 8'h03);
        dma_tc = 1'b1;
        cyc(1);
        dma_tc = 1'b0;
        cyc(2);
        chk({dma_req, sirq[6:0]}, 8'h03);
        re(8'h5d);
        wc(8'h14);
        $display("test dma done");
        wc(8'h74);
        for (i = 0; i < 3; i++) begin
            r = $random(seed);
            ql.push_back(r[7:0]);
            wr(ECPM_OFS_FIFO, r[7:0]);
        end
        want = 4'h3;
        cyc(24);
        chk({7'h0, xfer_fwd_ecp}, 8'h01);
        re(8'h75);
        wc(8'h64);
        fault_req = 1'b1;
        cyc(4);
        fault_req = 1'b0;
        cyc(2);
        wc(8'h74);
        fault_req = 1'b1;
        cyc(4);
        wc(8'h64);
        cyc(3);
        fault_req = 1'b0;
        cyc(2);
        chk(firq[7:0], 8'h02);
        want = 4'h0;
        wc(8'h34);
        direction = 1'b1;
        want = 4'h3;
        fifo_level_setting = 4'h1;
        wc(8'h70);
        cyc(24);
        chk({xfer_rev_ecp, sirq[6:0]}, 8'h84);
        rd(ECPM_OFS_FIFO, 8'h5a, 8'hff);
        rd(ECPM_OFS_FIFO, 8'h5b, 8'hff);
        rbusy = 1'b1;
        wc(8'h34);
        re(8'h35);
        rbusy = 1'b0;
        chk(alfn[7:0], 8'h01);
        direction = 1'b0;
        $display("test ecp done");
        print_verdict();
    end
endmodule : test_ecp_port_mode_control
`default_nettype wire
